//--- hdl/sfr_pkg.sv
// Package of constants and carrier types for the serial frame receiver.
package sfr_pkg;

   // ****************************************
   // Register map (word offsets on the plain port)
   // ****************************************
   localparam logic [2:0] SFR_ADDR_STATUS_A = 3'h0;
   localparam logic [2:0] SFR_ADDR_CTRL_B = 3'h1;
   localparam logic [2:0] SFR_ADDR_CTRL_C = 3'h2;
   localparam logic [2:0] SFR_ADDR_DATA = 3'h3;
   localparam logic [2:0] SFR_ADDR_BAUD = 3'h4;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int SFR_A_DONE = 7;
   localparam int SFR_A_FERR = 4;
   localparam int SFR_A_OVR = 3;
   localparam int SFR_A_PERR = 2;
   localparam int SFR_A_DBL = 1;
   localparam int SFR_B_IRQEN = 7;
   localparam int SFR_B_RECEIVE_ENABLE_BIT = 4;
   localparam int SFR_B_SZ2 = 2;
   localparam int SFR_B_NINTH = 1;
   localparam int SFR_C_SYNC = 6;
   localparam int SFR_C_PAR_EN = 5;
   localparam int SFR_C_PAR_ODD = 4;
   localparam int SFR_C_STOP2 = 3;
   localparam int SFR_C_SZ1 = 2;
   localparam int SFR_C_SZ0 = 1;

   // ****************************************
   // Reset values and counts
   // ****************************************
   localparam logic [7:0] SFR_CTRL_C_RST = 8'h06;
   localparam logic [7:0] SFR_BAUD_RST = 8'h00;
   localparam logic [3:0] SFR_SAMPLES_NORM = 4'hF;
   localparam logic [3:0] SFR_SAMPLES_DBL = 4'h7;
   localparam logic [3:0] SFR_VOTE_NORM = 4'h9;
   localparam logic [3:0] SFR_VOTE_DBL = 4'h5;
   localparam logic [2:0] SFR_SIZE_NINE = 3'h7;

   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic [7:0] data;
      logic ninth;
      logic ferr;
      logic ovr;
      logic perr;
   } sfr_entry_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sfr_bus_t;

   typedef enum logic [4:0] {
      SFR_IDLE = 5'h01,
      SFR_START = 5'h02,
      SFR_DATA = 5'h04,
      SFR_PAR = 5'h08,
      SFR_STOP = 5'h10
   } sfr_state_t;

endpackage

//--- hdl/sfr_receiver.sv
// Receive half of a serial port with a two-entry frame buffer.
//
// Function
// - Enable bit hands pin to receiver
// - Synchronous mode samples on external clock
// - Shift bits to first stop; ignore second
// - First stop moves frame into buffer
// - Short characters read with upper zeros
// - Ninth bit stored per entry
// - Done flag means buffer not empty
// - Disabling receiver flushes the buffer
// - Interrupt request follows done flag
// - Error flags stored with their frame
// - Status writes leave error flags alone
// - Error flags raise no interrupt
// - Frame error equals inverted first stop
// - Frame error ignores stop count setting
// - Overrun when full, waiting, new start
// - Overrun cleared by successful transfer
// - Parity error zero when checking off
// - Parity checked only when enabled
// - Odd select chooses parity type
// - Parity result stored with data
// - Parity error needs enable at receive
// - Disabling aborts reception at once
// - Sample at 16x or 8x baud
// - Majority of three centre samples
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module sfr_receiver (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Serial pins
   input wire logic rxd_i,
   input wire logic ext_sync_clock_pin_i,
   output logic pin_override_o,
   // Interrupt request
   input wire logic global_irq_en_i,
   output logic rx_done_irq_o
);
   import sfr_pkg::*;

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_q1;
   logic rst_n;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   sfr_bus_t bus;
   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   function automatic logic maj3(input logic [2:0] v);
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   function automatic logic hit(input sfr_bus_t b, input logic [2:0] a, input logic w);
      hit = (b.addr == a) && (w ? b.wr : b.rd);
   endfunction

   // ****************************************
   // Control registers
   // ****************************************
   logic irq_en;
   logic rx_enable;
   logic size2;
   logic dbl_speed;
   logic sync_mode;
   logic par_en;
   logic par_odd;
   logic stop2;
   logic [1:0] size10;
   logic [7:0] baud_div;
   logic [2:0] char_size_field;
   assign char_size_field = {size2, size10};

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_en <= 1'b0;
         rx_enable <= 1'b0;
         size2 <= 1'b0;
      end else if (hit(bus, SFR_ADDR_CTRL_B, 1'b1)) begin
         irq_en <= bus.wdata[SFR_B_IRQEN];
         rx_enable <= bus.wdata[SFR_B_RECEIVE_ENABLE_BIT];
         size2 <= bus.wdata[SFR_B_SZ2];
      end
   end

   // Only the speed bit is writable in status A; error flags live in the FIFO.
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         dbl_speed <= 1'b0;
      end else if (hit(bus, SFR_ADDR_STATUS_A, 1'b1)) begin
         dbl_speed <= bus.wdata[SFR_A_DBL];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         {sync_mode, par_en, par_odd, stop2, size10} <= SFR_CTRL_C_RST[6:1];
         baud_div <= SFR_BAUD_RST;
      end else if (hit(bus, SFR_ADDR_CTRL_C, 1'b1)) begin
         sync_mode <= bus.wdata[SFR_C_SYNC];
         par_en <= bus.wdata[SFR_C_PAR_EN];
         par_odd <= bus.wdata[SFR_C_PAR_ODD];
         stop2 <= bus.wdata[SFR_C_STOP2];
         size10 <= {bus.wdata[SFR_C_SZ1], bus.wdata[SFR_C_SZ0]};
      end else if (hit(bus, SFR_ADDR_BAUD, 1'b1)) begin
         baud_div <= bus.wdata;
      end
   end

   assign pin_override_o = rx_enable;

   // ****************************************
   // Sample tick: baud divider or external clock edge
   // ****************************************
   logic [7:0] div_cnt;
   logic xck_q;
   logic tick;
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 8'h00;
         xck_q <= 1'b0;
      end else begin
         xck_q <= ext_sync_clock_pin_i;
         if (div_cnt == 8'h00 || !rx_enable) begin
            div_cnt <= baud_div;
         end else begin
            div_cnt <= div_cnt - 8'h01;
         end
      end
   end
   // In synchronous mode each rising external edge is one whole bit.
   assign tick = sync_mode ? (ext_sync_clock_pin_i & ~xck_q) : (div_cnt == 8'h00);

   // ****************************************
   // Receive state machine
   // ****************************************
   sfr_state_t state;
   logic [3:0] smp;
   logic [2:0] votes;
   logic [3:0] bitn;
   logic [8:0] shreg;
   logic par_acc;
   logic par_bad;
   logic [3:0] last_smp;
   logic [3:0] vote_mid;
   logic bit_val;
   logic bit_end;
   logic [3:0] nbits;
   logic frame_done;
   logic frame_ferr;
   logic start_seen;

   assign last_smp = dbl_speed ? SFR_SAMPLES_DBL : SFR_SAMPLES_NORM;
   assign vote_mid = dbl_speed ? SFR_VOTE_DBL : SFR_VOTE_NORM;
   assign nbits = (char_size_field == SFR_SIZE_NINE) ? 4'h9 : {2'b00, size10} + 4'h5;
   assign bit_val = sync_mode ? rxd_i : maj3(votes);
   assign bit_end = tick && (sync_mode || smp == last_smp);
   assign start_seen = (state == SFR_IDLE) && rx_enable && tick && !rxd_i;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         votes <= 3'h0;
      end else if (tick && (smp == vote_mid - 4'h1 || smp == vote_mid ||
                            smp == vote_mid + 4'h1)) begin
         votes <= {votes[1:0], rxd_i};
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= SFR_IDLE;
         smp <= 4'h0;
         bitn <= 4'h0;
         shreg <= 9'h000;
         par_acc <= 1'b0;
         par_bad <= 1'b0;
         frame_done <= 1'b0;
         frame_ferr <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         if (!rx_enable) begin
            state <= SFR_IDLE;
            smp <= 4'h0;
         end else begin
            if (tick) begin
               smp <= (state == SFR_IDLE || smp == last_smp) ? 4'h0 : smp + 4'h1;
            end
            case (state)
               SFR_IDLE: begin
                  if (start_seen) begin
                     state <= sync_mode ? SFR_DATA : SFR_START;
                     smp <= 4'h1;
                     bitn <= 4'h0;
                     shreg <= 9'h000;
                     par_acc <= par_odd;
                  end
               end
               SFR_START: begin
                  // A start whose centre votes high is a glitch and is dropped.
                  if (tick && smp == vote_mid + 4'h1 && maj3({votes[1:0], rxd_i})) begin
                     state <= SFR_IDLE;
                  end else if (bit_end) begin
                     state <= SFR_DATA;
                  end
               end
               SFR_DATA: begin
                  if (bit_end) begin
                     shreg[bitn] <= bit_val;
                     par_acc <= par_acc ^ bit_val;
                     bitn <= bitn + 4'h1;
                     if (bitn == nbits - 4'h1) begin
                        state <= par_en ? SFR_PAR : SFR_STOP;
                     end
                  end
               end
               SFR_PAR: begin
                  if (bit_end) begin
                     par_bad <= par_acc ^ bit_val;
                     state <= SFR_STOP;
                  end
               end
               SFR_STOP: begin
                  // Only the first stop is examined; a second one looks idle.
                  if (bit_end) begin
                     frame_ferr <= ~bit_val;
                     frame_done <= 1'b1;
                     state <= SFR_IDLE;
                     if (!par_en) begin
                        par_bad <= 1'b0;
                     end
                  end
               end
               default: state <= SFR_IDLE;
            endcase
         end
      end
   end

   // ****************************************
   // Holding stage and two-entry FIFO
   // ****************************************
   sfr_entry_t fifo [2];
   sfr_entry_t held;
   logic held_valid;
   logic rd_ptr;
   logic [1:0] count;
   logic ovr_pend;
   logic data_rd;
   logic push;
   logic pop;
   assign data_rd = hit(bus, SFR_ADDR_DATA, 1'b0);
   assign pop = data_rd && count != 2'h0;
   assign push = held_valid && (count != 2'h2 || pop);

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         held <= '0;
         held_valid <= 1'b0;
         ovr_pend <= 1'b0;
      end else if (!rx_enable) begin
         held_valid <= 1'b0;
         ovr_pend <= 1'b0;
      end else begin
         if (start_seen && held_valid && count == 2'h2 && !pop) begin
            ovr_pend <= 1'b1;
         end else if (push) begin
            ovr_pend <= 1'b0;
         end
         if (frame_done) begin
            held.data <= shreg[7:0] & ~(8'hFF << nbits);
            held.ninth <= (nbits == 4'h9) & shreg[8];
            held.ferr <= frame_ferr;
            held.perr <= par_en & par_bad;
            held_valid <= 1'b1;
         end else if (push) begin
            held_valid <= 1'b0;
         end
      end
   end

   logic [1:0] next_count;
   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 2'h1;
      end else if (pop && !push) begin
         next_count = count - 2'h1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         count <= 2'h0;
         rd_ptr <= 1'b0;
         fifo[0] <= '0;
         fifo[1] <= '0;
      end else if (!rx_enable) begin
         count <= 2'h0;
         rd_ptr <= 1'b0;
      end else begin
         count <= next_count;
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push) begin
            // The overrun mark rides with the frame that follows the gap.
            fifo[rd_ptr ^ count[0]] <= '{data: held.data, ninth: held.ninth,
               ferr: held.ferr, ovr: ovr_pend, perr: held.perr};
         end
      end
   end

   // ****************************************
   // Read data and interrupt
   // ****************************************
   sfr_entry_t head;
   logic rx_done;
   assign head = fifo[rd_ptr];
   assign rx_done = count != 2'h0;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            SFR_ADDR_STATUS_A: rdata_o <= ({7'h00, rx_done} << SFR_A_DONE) |
               ({7'h00, head.ferr & rx_done} << SFR_A_FERR) |
               ({7'h00, head.ovr & rx_done} << SFR_A_OVR) |
               ({7'h00, head.perr & rx_done} << SFR_A_PERR) |
               ({7'h00, dbl_speed} << SFR_A_DBL);
            SFR_ADDR_CTRL_B: rdata_o <= ({7'h00, irq_en} << SFR_B_IRQEN) |
               ({7'h00, rx_enable} << SFR_B_RECEIVE_ENABLE_BIT) | ({7'h00, size2} << SFR_B_SZ2) |
               ({7'h00, head.ninth} << SFR_B_NINTH);
            SFR_ADDR_CTRL_C: rdata_o <= {1'b0, sync_mode, par_en, par_odd, stop2,
               size10, 1'b0};
            SFR_ADDR_DATA: rdata_o <= rx_done ? head.data : 8'h00;
            SFR_ADDR_BAUD: rdata_o <= baud_div;
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // Error flags are deliberately kept out of this term.
   assign rx_done_irq_o = irq_en & global_irq_en_i & rx_done;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   irq_follows_done_a: assert property (
      rx_done_irq_o == (irq_en && global_irq_en_i && count != 2'h0)) else $error("irq level");
   disable_flushes_a: assert property (!rx_enable |=> count == 2'h0) else $error("flush");
   pin_follows_en_a: assert property (pin_override_o == rx_enable) else $error("pin drive");
   ovr_clears_a: assert property (
      push && rx_enable |=> !ovr_pend) else $error("overrun stuck");
   perr_off_a: assert property (
      frame_done && !par_en |=> !held.perr) else $error("parity flag set");
   ferr_stop_a: assert property (
      frame_done && rx_enable |=> held.ferr == $past(frame_ferr)) else $error("frame error");
   count_limit_a: assert property (count <= 2'h2) else $error("fifo overflow");
   pop_moves_a: assert property (
      pop && !push && rx_enable |=> count == $past(count) - 2'h1) else $error("pop lost");
   abort_idle_a: assert property (!rx_enable |=> state == SFR_IDLE) else $error("abort");
   status_write_a: assert property (
      hit(bus, SFR_ADDR_STATUS_A, 1'b1) && rx_enable && !push |=> $stable(head))
      else $error("status write");

   frame_cov: cover property (frame_done);
   full_cov: cover property (count == 2'h2);
   ovr_cov: cover property (ovr_pend && push);
endmodule

//--- bench/sfr_tx_model.sv
// Behavioural remote transmitter that drives the receive line.
`timescale 1ns/10ps
module sfr_tx_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Frame request
   input wire logic go_i,
   input wire logic [11:0] frame_i,
   input wire logic [3:0] nbits_i,
   input wire logic [4:0] blen_i,
   input wire logic sync_i,
   // Line side
   output logic txd_o,
   output logic sclk_o,
   output logic busy_o
);
   logic [11:0] sh;
   logic [3:0] left;
   logic [4:0] cnt;

   // Bits leave lowest first; blen_i clock cycles stand for one bit.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_o <= 1'b0;
         sh <= 12'hFFF;
         left <= 4'h0;
         cnt <= 5'h00;
      end else if (!busy_o) begin
         if (go_i) begin
            busy_o <= 1'b1;
            sh <= frame_i;
            left <= nbits_i;
            cnt <= 5'h00;
         end
      end else if (cnt == blen_i - 5'h01) begin
         cnt <= 5'h00;
         sh <= {1'b1, sh[11:1]};
         left <= left - 4'h1;
         busy_o <= (left != 4'h1);
      end else begin
         cnt <= cnt + 5'h01;
      end
   end

   // The line idles high between frames, so no stale bit lingers there.
   assign txd_o = busy_o ? sh[0] : 1'b1;
   // The bit clock stands low outside frames and rises once in mid-bit.
   assign sclk_o = sync_i & busy_o & (cnt >= (blen_i >> 1));
endmodule

//--- bench/sfr_receiver_tb.sv
// Self-checking bench for the serial frame receiver.
`timescale 1ns/10ps
module sfr_receiver_tb;
   import sfr_pkg::*;

   typedef struct packed {
      logic [8:0] d;
      logic [2:0] sz;
      logic pen;
      logic odd;
      logic pflip;
      logic stopv;
      logic stop2;
      logic dbl;
   } sfr_row_t;

   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic go = 1'b0;
   logic sync = 1'b0;
   logic gl = 1'b0;
   logic gie = 1'b1;
   logic acc = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic [11:0] fbits = 12'hFFF;
   logic [3:0] nb = 4'h0;
   logic [4:0] blen = 5'h10;
   logic [7:0] rdata_o, v, ex;
   logic busy, txd, sclk, rxd, pin_o, irq_o;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   int j;
   sfr_row_t r;
   // Fields: data, size, parity on, odd, bad parity, stop level, two stops, double speed.
   sfr_row_t rows [10] = '{
      '{9'h0A5, 3'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
      '{9'h0FF, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
      '{9'h0C3, 3'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1},
      '{9'h0F0, 3'h2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
      '{9'h1A5, 3'h7, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
      '{9'h05A, 3'h3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
      '{9'h05B, 3'h3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0},
      '{9'h033, 3'h3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1},
      '{9'h081, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
      '{9'h17E, 3'h7, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0}};

   assign rxd = txd & ~gl;

   sfr_receiver sfr_receiver_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd),
      .ext_sync_clock_pin_i(sclk), .pin_override_o(pin_o), .global_irq_en_i(gie),
      .rx_done_irq_o(irq_o));

   sfr_tx_model sfr_tx_model_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .go_i(go),
      .frame_i(fbits), .nbits_i(nb), .blen_i(blen), .sync_i(sync), .txd_o(txd),
      .sclk_o(sclk), .busy_o(busy));

   initial begin
      forever #25 mclk_i = ~mclk_i;
   end

   // A run should end near 3000 cycles; the ceiling leaves wide room.
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic conclude();
      if (n_fail == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp1(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask

   function automatic int nbits(input logic [2:0] sz);
      return (sz == SFR_SIZE_NINE) ? 9 : 5 + int'(sz);
   endfunction

   // Builds start, data LSB first, optional parity and one stop, then hands it over.
   task automatic send(input sfr_row_t s, input bit w);
      int n, k, i;
      logic [8:0] dm;
      logic [11:0] fr;
      n = nbits(s.sz);
      dm = s.d & (9'h1FF >> (9 - n));
      fr = 12'hFFF;
      fr[0] = 1'b0;
      for (i = 0; i < n; i++) fr[i + 1] = dm[i];
      k = n + 1;
      if (s.pen) begin
         fr[k] = ^dm ^ s.odd ^ s.pflip;
         k++;
      end
      fr[k] = s.stopv;
      @(posedge mclk_i);
      fbits <= fr;
      nb <= 4'(k + 1);
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      // The model shows busy only one edge after it has taken go.
      @(posedge mclk_i);
      for (i = 0; i < 400 && w && busy; i++) @(posedge mclk_i);
      if (w) repeat (4) @(posedge mclk_i);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge mclk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      #1 cmp1("pin_override_o", 1'b0, pin_o);
      cmp1("rx_done_irq_o", 1'b0, irq_o);
      rd(SFR_ADDR_CTRL_C);
      cmp8("ctrl_c reset", SFR_CTRL_C_RST, v);
      rd(SFR_ADDR_BAUD);
      cmp8("baud reset", SFR_BAUD_RST, v);
      rd(3'h7);
      cmp8("unmapped read", 8'h00, v);
      rd(SFR_ADDR_DATA);
      cmp8("empty data read", 8'h00, v);
      wr(SFR_ADDR_CTRL_B, 8'h90);
      cmp1("pin_override_o", 1'b1, pin_o);
      @(posedge mclk_i);
      gl <= 1'b1;
      repeat (3) @(posedge mclk_i);
      gl <= 1'b0;
      repeat (40) @(posedge mclk_i);
      rd(SFR_ADDR_STATUS_A);
      cmp8("done after spike", 8'h00, v & 8'h80);
      foreach (rows[i]) begin
         r = rows[i];
         blen <= r.dbl ? 5'h08 : 5'h10;
         wr(SFR_ADDR_STATUS_A, {6'h00, r.dbl, 1'b0});
         wr(SFR_ADDR_CTRL_C, {2'b00, r.pen, r.odd, r.stop2, r.sz[1:0], 1'b0});
         wr(SFR_ADDR_CTRL_B, {5'b10010, r.sz[2], 2'b00});
         send(r, 1'b1);
         cmp1("rx_done_irq_o", 1'b1, irq_o);
         wr(SFR_ADDR_STATUS_A, {6'h00, r.dbl, 1'b0});
         rd(SFR_ADDR_STATUS_A);
         ex = {3'b100, ~r.stopv, 1'b0, r.pen & r.pflip, 2'b00};
         cmp8("status_a", ex, v & 8'h9C);
         rd(SFR_ADDR_CTRL_B);
         if (r.sz == SFR_SIZE_NINE) cmp1("ninth bit", r.d[8], v[SFR_B_NINTH]);
         rd(SFR_ADDR_DATA);
         cmp8("data", r.d[7:0] & 8'(9'h1FF >> (9 - nbits(r.sz))), v);
         rd(SFR_ADDR_STATUS_A);
         cmp8("done after read", 8'h00, v & 8'h80);
         cmp1("rx_done_irq_o", 1'b0, irq_o);
      end
      // Four frames with no reads: the fourth finds buffer and holding stage full.
      blen <= 5'h10;
      wr(SFR_ADDR_STATUS_A, 8'h00);
      wr(SFR_ADDR_CTRL_C, SFR_CTRL_C_RST);
      wr(SFR_ADDR_CTRL_B, 8'h90);
      r = rows[0];
      for (j = 0; j < 4; j++) begin
         r.d = 9'(17 * (j + 1));
         send(r, 1'b1);
      end
      for (j = 0; j < 3; j++) begin
         rd(SFR_ADDR_STATUS_A);
         acc = acc | v[SFR_A_OVR];
         rd(SFR_ADDR_DATA);
         // The fourth frame replaces the waiting third one, so the third is the lost frame.
         cmp8("fifo order", 8'(17 * (j + 1 + j / 2)), v);
      end
      cmp1("overrun seen", 1'b1, acc);
      rd(SFR_ADDR_STATUS_A);
      cmp8("lost frame absent", 8'h00, v & 8'h80);
      send(rows[0], 1'b1);
      rd(SFR_ADDR_STATUS_A);
      cmp8("overrun cleared", 8'h80, v & 8'h88);
      @(posedge mclk_i);
      gie <= 1'b0;
      @(posedge mclk_i);
      #1 cmp1("irq global off", 1'b0, irq_o);
      @(posedge mclk_i);
      gie <= 1'b1;
      send(rows[0], 1'b0);
      repeat (60) @(posedge mclk_i);
      wr(SFR_ADDR_CTRL_B, 8'h80);
      cmp1("pin released", 1'b0, pin_o);
      // The flush acts on the edge after the enable register has dropped.
      @(posedge mclk_i);
      #1 cmp1("irq after flush", 1'b0, irq_o);
      for (j = 0; j < 400 && busy; j++) @(posedge mclk_i);
      wr(SFR_ADDR_CTRL_B, 8'h90);
      repeat (20) @(posedge mclk_i);
      rd(SFR_ADDR_STATUS_A);
      cmp8("flushed", 8'h00, v & 8'h80);
      // Synchronous mode with the done interrupt enable off.
      wr(SFR_ADDR_CTRL_C, SFR_CTRL_C_RST | 8'h40);
      wr(SFR_ADDR_CTRL_B, 8'h10);
      sync <= 1'b1;
      send(rows[0], 1'b1);
      cmp1("irq enable off", 1'b0, irq_o);
      rd(SFR_ADDR_DATA);
      cmp8("sync data", 8'hA5, v);
      conclude();
   end
endmodule
